// [src/iowd_consts.vh]
/*
 Constants for the I/O watchdog and panel indicator register block:
 port addresses, field positions, reset values and timeout figures.
 Assumes inclusion by bare name from the design files only.
*/
// Behaviour
// - Bit 0 of the watchdog control port disables the watchdog at 0 and enables it at 1.
// - With control bit 1 at 0 the timeout code in bits 5:3 picks 94 to 960 ms, code 0 by default.
// - With control bit 1 at 1 the same code picks 2, 4, 6, 8, 16, 32, 48 or 64 s.
// - Control bit 7 reads 1 after an alarm and clears on a write of 1, and bit 6 drives the red indicator.
// - A read of the retrigger port retriggers the watchdog only while control bit 2 is set, and returns meaningless data.
// - The indicator register is one 16-bit read/write register on two byte ports.
// - Bits 15 and 7 steer the run/stop indicator: dark, yellow or green.
// - Bits 14 and 6 steer the fault indicator: dark, red or yellow.
// - Bits 13 and 5 steer the maintenance indicator: dark, red or yellow.
// - All indicators are dark after reset and the reserved bits stay read/write.
// - The read-only battery port reports the battery state in bits 7:6.
// - The nonvolatile window is 512 KB long with a base register defaulting to E3000000h.
`ifndef IOWD_CONSTS_VH
`define IOWD_CONSTS_VH

// Port addresses
`define IOWD_ADDR_CTRL      16'h0062
`define IOWD_ADDR_RETRIG    16'h0066
`define IOWD_ADDR_BATT      16'h404D
`define IOWD_ADDR_LED_LO    16'h404E
`define IOWD_ADDR_LED_HI    16'h404F

// Control register fields
`define IOWD_CTRL_EN        0
`define IOWD_CTRL_MACRO     1
`define IOWD_CTRL_SEL       2
`define IOWD_CTRL_TO_LO     3
`define IOWD_CTRL_TO_HI     5
`define IOWD_CTRL_LED       6
`define IOWD_CTRL_ALARM     7
`define IOWD_CTRL_RST       8'h00

// Indicator register
`define IOWD_LED_RST        16'hFFFF
`define IOWD_LED_RUN_HI     15
`define IOWD_LED_FLT_HI     14
`define IOWD_LED_MNT_HI     13
`define IOWD_LED_RUN_LO     7
`define IOWD_LED_FLT_LO     6
`define IOWD_LED_MNT_LO     5
`define IOWD_BATT_HI        7
`define IOWD_BATT_LO        6

// Colour codes of an indicator
`define IOWD_COL_DARK       2'h0
`define IOWD_COL_YELLOW     2'h1
`define IOWD_COL_GREEN      2'h2
`define IOWD_COL_RED        2'h3

// Nonvolatile window
`define IOWD_NV_BASE_RST    32'hE3000000
`define IOWD_NV_LEN         32'h00080000

// Timing: clock rate and a 1 ms tick
`define IOWD_CLK_HZ         40000000
// Cycles per ms at IOWD_CLK_HZ, sized to the 16-bit prescaler
`define IOWD_MS_CYC         16'd40000
`define IOWD_MS_W           16
`define IOWD_TMO_W          17

// Timeouts in ms, standard range
`define IOWD_STD_0          17'd94
`define IOWD_STD_1          17'd210
`define IOWD_STD_2          17'd340
`define IOWD_STD_3          17'd460
`define IOWD_STD_4          17'd590
`define IOWD_STD_5          17'd710
`define IOWD_STD_6          17'd840
`define IOWD_STD_7          17'd960
// Timeouts in ms, extended range (2..64 s)
`define IOWD_EXT_0          17'd2000
`define IOWD_EXT_1          17'd4000
`define IOWD_EXT_2          17'd6000
`define IOWD_EXT_3          17'd8000
`define IOWD_EXT_4          17'd16000
`define IOWD_EXT_5          17'd32000
`define IOWD_EXT_6          17'd48000
`define IOWD_EXT_7          17'd64000

`endif

// [src/iowd_timer.v]
/*
 Watchdog timeout counter: a millisecond prescaler and a millisecond
 count against the selected limit. Assumes one clock, sync reset.
*/
`timescale 1ns/1ps
`include "iowd_consts.vh"

module iowd_timer #(
	parameter [15:0] MS_CYC = `IOWD_MS_CYC
) (
	input  wire        clk_sys,
	input  wire        reset_n,
	input  wire        enable,
	input  wire        macro,
	input  wire [2:0]  code,
	input  wire        retrigger,
	output reg         expire_q
);

	reg  [`IOWD_MS_W-1:0]  pre_q;
	reg  [`IOWD_TMO_W-1:0] ms_q;
	reg  [`IOWD_TMO_W-1:0] limit;
	wire                   tick;

	// Limit table in ms for both ranges
	always @* begin
		limit = `IOWD_STD_0;
		if (macro) begin
			case (code)
			3'h0: limit = `IOWD_EXT_0;
			3'h1: limit = `IOWD_EXT_1;
			3'h2: limit = `IOWD_EXT_2;
			3'h3: limit = `IOWD_EXT_3;
			3'h4: limit = `IOWD_EXT_4;
			3'h5: limit = `IOWD_EXT_5;
			3'h6: limit = `IOWD_EXT_6;
			default: limit = `IOWD_EXT_7;
			endcase
		end else begin
			case (code)
			3'h0: limit = `IOWD_STD_0;
			3'h1: limit = `IOWD_STD_1;
			3'h2: limit = `IOWD_STD_2;
			3'h3: limit = `IOWD_STD_3;
			3'h4: limit = `IOWD_STD_4;
			3'h5: limit = `IOWD_STD_5;
			3'h6: limit = `IOWD_STD_6;
			default: limit = `IOWD_STD_7;
			endcase
		end
	end

	assign tick = (pre_q == MS_CYC - 16'h0001);

	// Prescaler and ms counter; disabled or retriggered restarts both
	always @(posedge clk_sys) begin
		expire_q <= 1'b0;
		if (!reset_n || !enable || retrigger) begin
			pre_q <= {`IOWD_MS_W{1'b0}};
			ms_q  <= {`IOWD_TMO_W{1'b0}};
		end else begin
			pre_q <= tick ? {`IOWD_MS_W{1'b0}} : pre_q + 16'h0001;
			if (tick) begin
				// Expiry one pulse, then count again for next period
				if (ms_q + 17'h00001 >= limit) begin
					ms_q     <= {`IOWD_TMO_W{1'b0}};
					expire_q <= 1'b1;
				end else begin
					ms_q <= ms_q + 17'h00001;
				end
			end
		end
	end

endmodule

// [src/iowd_regs.v]
/*
 I/O-mapped register block: watchdog control and retrigger ports,
 16-bit panel indicator register, battery status port and the base
 register of the nonvolatile window. Assumes a simple synchronous
 port bus: one-cycle io_rd/io_wr strobes with a 16-bit port address
 and byte data; reads answer on the next edge.
*/
`timescale 1ns/1ps
`include "iowd_consts.vh"

module iowd_regs #(
	parameter [15:0] MS_CYC = `IOWD_MS_CYC
) (
	input  wire        clk_sys,
	input  wire        reset_n,
	input  wire [15:0] io_addr,
	input  wire        io_wr,
	input  wire        io_rd,
	input  wire [7:0]  io_wdata,
	output reg  [7:0]  io_rdata_q,
	output reg         io_rvalid_q,
	input  wire [1:0]  battery_level,
	input  wire [31:0] nv_base_wdata,
	input  wire        nv_base_wr,
	output reg  [31:0] nv_base_q,
	output reg  [31:0] nv_len_q,
	output reg         watchdog_alarm_indicator_q,
	output reg         watchdog_expired_q,
	output reg  [1:0]  user_indicator_one_q,
	output reg  [1:0]  user_indicator_two_q,
	output reg  [1:0]  user_indicator_three_q
);

	reg  [7:0]  ctrl_q;
	reg  [15:0] led_q;
	reg  [7:0]  rd_d;
	wire        expire;
	wire        wr_ctrl;
	wire        retrig;
	wire        alarm_clr;

	assign wr_ctrl   = io_wr && (io_addr == `IOWD_ADDR_CTRL);
	// Read of retrigger port only counts when select bit is set
	assign retrig    = io_rd && (io_addr == `IOWD_ADDR_RETRIG)
		&& ctrl_q[`IOWD_CTRL_SEL];
	assign alarm_clr = wr_ctrl && io_wdata[`IOWD_CTRL_ALARM];

	iowd_timer #(
		.MS_CYC (MS_CYC)
	) u_timer (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.enable    (ctrl_q[`IOWD_CTRL_EN]),
		.macro     (ctrl_q[`IOWD_CTRL_MACRO]),
		.code      (ctrl_q[`IOWD_CTRL_TO_HI:`IOWD_CTRL_TO_LO]),
		.retrigger (retrig),
		.expire_q  (expire)
	);

	// Control register; alarm set wins over a same-cycle clear
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			ctrl_q <= `IOWD_CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q[6:0] <= io_wdata[6:0];
			end
			if (expire) begin
				ctrl_q[`IOWD_CTRL_ALARM] <= 1'b1;
			end else if (alarm_clr) begin
				ctrl_q[`IOWD_CTRL_ALARM] <= 1'b0;
			end
		end
	end

	// Indicator register, byte ports; reserved bits kept as written
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			led_q <= `IOWD_LED_RST;
		end else if (io_wr) begin
			if (io_addr == `IOWD_ADDR_LED_LO)
				led_q[7:0] <= io_wdata;
			if (io_addr == `IOWD_ADDR_LED_HI)
				led_q[15:8] <= io_wdata;
		end
	end

	// Window base: writable from the config side, reset to default
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			nv_base_q <= `IOWD_NV_BASE_RST;
			nv_len_q  <= `IOWD_NV_LEN;
		end else if (nv_base_wr) begin
			nv_base_q <= nv_base_wdata;
		end
	end

	// Read multiplexer; unmapped ports and the retrigger port read 0
	always @* begin
		rd_d = 8'h00;
		case (io_addr)
		`IOWD_ADDR_CTRL:   rd_d = ctrl_q;
		`IOWD_ADDR_LED_LO: rd_d = led_q[7:0];
		`IOWD_ADDR_LED_HI: rd_d = led_q[15:8];
		`IOWD_ADDR_BATT:   rd_d = {battery_level, 6'h00};
		default:           rd_d = 8'h00;
		endcase
	end

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			io_rdata_q  <= 8'h00;
			io_rvalid_q <= 1'b0;
		end else begin
			io_rvalid_q <= io_rd;
			if (io_rd)
				io_rdata_q <= rd_d;
		end
	end

	// Indicator decode, registered so outputs come from flip-flops
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			user_indicator_one_q       <= `IOWD_COL_DARK;
			user_indicator_two_q       <= `IOWD_COL_DARK;
			user_indicator_three_q     <= `IOWD_COL_DARK;
			watchdog_alarm_indicator_q <= 1'b0;
			watchdog_expired_q         <= 1'b0;
		end else begin
			// Run/stop: high bit 0 means green whatever the low bit
			if (!led_q[`IOWD_LED_RUN_HI])
				user_indicator_one_q <= `IOWD_COL_GREEN;
			else if (!led_q[`IOWD_LED_RUN_LO])
				user_indicator_one_q <= `IOWD_COL_YELLOW;
			else
				user_indicator_one_q <= `IOWD_COL_DARK;
			// Fault: high bit 0 means red
			if (!led_q[`IOWD_LED_FLT_HI])
				user_indicator_two_q <= `IOWD_COL_RED;
			else if (!led_q[`IOWD_LED_FLT_LO])
				user_indicator_two_q <= `IOWD_COL_YELLOW;
			else
				user_indicator_two_q <= `IOWD_COL_DARK;
			// Maintenance: same scheme as fault
			if (!led_q[`IOWD_LED_MNT_HI])
				user_indicator_three_q <= `IOWD_COL_RED;
			else if (!led_q[`IOWD_LED_MNT_LO])
				user_indicator_three_q <= `IOWD_COL_YELLOW;
			else
				user_indicator_three_q <= `IOWD_COL_DARK;
			watchdog_alarm_indicator_q <= ctrl_q[`IOWD_CTRL_LED];
			watchdog_expired_q <= ctrl_q[`IOWD_CTRL_ALARM];
		end
	end

endmodule

// [tb/iowd_asserts.sv]
/* Port checks of the watchdog register block.
 Assumes a bind to iowd_regs, one clock, sync active-low reset. */
`timescale 1ns/1ps
module iowd_asserts (
	input wire        clk_sys,
	input wire        reset_n,
	input wire [15:0] io_addr,
	input wire        io_wr,
	input wire        io_rd,
	input wire [7:0]  io_wdata,
	input wire [7:0]  io_rdata_q,
	input wire        io_rvalid_q,
	input wire [1:0]  battery_level,
	input wire [31:0] nv_base_wdata,
	input wire        nv_base_wr,
	input wire [31:0] nv_base_q,
	input wire [31:0] nv_len_q,
	input wire        watchdog_expired_q,
	input wire [1:0]  user_indicator_one_q,
	input wire [1:0]  user_indicator_two_q,
	input wire [1:0]  user_indicator_three_q
);
	// One domain, so clock and reset are shared
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	property p_rv; io_rd |=> io_rvalid_q; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_rv1; !io_rd |=> !io_rvalid_q; endproperty
	a_rv1: assert property (p_rv1) else $error("stray rvalid");
	property p_len; nv_len_q == 32'h00080000; endproperty
	a_len: assert property (p_len) else $error("bad length");
	property p_bat;
		io_rd && io_addr == 16'h404D |=>
			io_rdata_q == {$past(battery_level), 6'h00};
	endproperty
	a_bat: assert property (p_bat) else $error("bad battery");
	property p_c1; user_indicator_one_q != 2'h3; endproperty
	a_c1: assert property (p_c1) else $error("run colour");
	property p_c2; user_indicator_two_q != 2'h2; endproperty
	a_c2: assert property (p_c2) else $error("fault colour");
	property p_c3; user_indicator_three_q != 2'h2; endproperty
	a_c3: assert property (p_c3) else $error("maint colour");
	property p_nvb; nv_base_wr |=> nv_base_q == $past(nv_base_wdata);
	endproperty
	a_nvb: assert property (p_nvb) else $error("base not loaded");
	// Alarm drops only after a write of 1 to bit 7
	property p_clr;
		$fell(watchdog_expired_q) |->
			$past(io_wr && io_addr == 16'h0062 && io_wdata[7], 2);
	endproperty
	a_clr: assert property (p_clr) else $error("alarm lost");
endmodule
bind iowd_regs iowd_asserts u_chk (.*);

// [tb/tb.sv]
/* Self-checking bench of the watchdog register block.
 Assumes iowd_regs with MS_CYC 4; bus driven at falling edges. */
`timescale 1ns/1ps
module tb;
	reg clk_sys = 0, reset_n = 0, io_wr = 0, io_rd = 0, nv_base_wr = 0;
	reg [15:0] io_addr = 16'h0000;
	reg [7:0] io_wdata = 8'h00, d;
	reg [1:0] battery_level = 2'h0;
	reg [31:0] nv_base_wdata = 32'h00000000;
	wire [7:0] io_rdata_q;
	wire io_rvalid_q, watchdog_alarm_indicator_q, watchdog_expired_q;
	wire [31:0] nv_base_q, nv_len_q;
	wire [1:0] user_indicator_one_q, user_indicator_two_q;
	wire [1:0] user_indicator_three_q;
	integer n_fail = 0, num_checks = 0, i;
	integer ms[8] = '{94, 210, 340, 460, 590, 710, 840, 960};
	reg [21:0] tbl[3] = '{{16'hFF1F, 6'h15}, {16'h1FE0, 6'h2F},
		{16'h7F00, 6'h25}};
	iowd_regs #(.MS_CYC(16'h0004)) uut (.*);
	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g); begin
		num_checks = num_checks + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("[ERR] %0s exp %h got %h", nm, e, g);
		end
	end endtask
	task cyc(input integer n); repeat (n) @(negedge clk_sys); endtask
	task wr(input [15:0] a, input [7:0] v); begin
		@(negedge clk_sys); io_addr = a; io_wdata = v; io_wr = 1;
		@(negedge clk_sys); io_wr = 0;
	end endtask
	// Answer is settled by the next falling edge
	task rd(input [15:0] a); begin
		@(negedge clk_sys); io_addr = a; io_rd = 1;
		@(negedge clk_sys); io_rd = 0;
		chk("rvalid", 1, io_rvalid_q); d = io_rdata_q;
	end endtask
	// Margin of 8 cycles covers prescaler phase and output stages
	task wdt(input [7:0] c, input integer lim); begin
		wr(16'h0062, c); cyc(lim - 8);
		chk("early", 0, watchdog_expired_q); cyc(16);
		chk("expired", 1, watchdog_expired_q);
		rd(16'h0062); chk("alarm", 1, d[7]);
		wr(16'h0062, 8'h84); rd(16'h0062); chk("cleared", 0, d[7]);
	end endtask
	task finish_test; begin
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end endtask
	// Main sequence
	initial begin
		cyc(6); reset_n = 1;
		rd(16'h0062); chk("ctrl", 0, d);
		rd(16'h404E); chk("led lo", 8'hFF, d);
		rd(16'h404F); chk("led hi", 8'hFF, d);
		chk("dark", 0, {user_indicator_one_q, user_indicator_two_q,
			user_indicator_three_q});
		chk("base", 32'hE3000000, nv_base_q);
		for (i = 0; i < 3; i = i + 1) begin
			wr(16'h404E, tbl[i][13:6]); wr(16'h404F, tbl[i][21:14]); cyc(2);
			chk("colour", tbl[i][5:0], {user_indicator_one_q,
				user_indicator_two_q, user_indicator_three_q});
			rd(16'h404E); chk("lo back", tbl[i][13:6], d);
			rd(16'h404F); chk("hi back", tbl[i][21:14], d);
		end
		for (i = 0; i < 3; i = i + 1) begin
			battery_level = (i == 2) ? 2'h3 : i[1:0];
			wr(16'h404D, 8'hFF); rd(16'h404D);
			chk("battery", {battery_level, 6'h00}, d);
		end
		rd(16'h0063); chk("unmapped", 0, d);
		@(negedge clk_sys); nv_base_wdata = 32'h12345678; nv_base_wr = 1;
		@(negedge clk_sys); nv_base_wr = 0;
		chk("base wr", 32'h12345678, nv_base_q);
		wr(16'h0062, 8'h40); cyc(2);
		chk("red", 1, watchdog_alarm_indicator_q);
		wr(16'h0062, 8'h00); cyc(2);
		chk("red off", 0, watchdog_alarm_indicator_q);
		for (i = 0; i < 8; i = i + 1)
			wdt({2'b00, i[2:0], 3'b101}, ms[i] * 4);
		wdt(8'h07, 2000 * 4);
		wr(16'h0062, 8'h05);
		repeat (3) begin cyc(300); rd(16'h0066); end
		chk("retrig", 0, watchdog_expired_q);
		wr(16'h0062, 8'h84); wr(16'h0062, 8'h01); cyc(250); rd(16'h0066);
		cyc(150); chk("no sel", 1, watchdog_expired_q);
		wr(16'h0062, 8'h84); cyc(500);
		chk("disabled", 0, watchdog_expired_q);
		finish_test;
	end
	// Hang guard, about twice the expected run
	initial begin
		cyc(60000); n_fail = n_fail + 1; finish_test;
	end
endmodule
